// >>> hdl/rtc_pkg.sv
package rtc_pkg;

	// Clock rate and oscillator-loss detection window.
	localparam int unsigned CLK_MHZ         = 125;
	localparam int unsigned OSC_STOP_US     = 100;
	localparam int unsigned OSC_STOP_CYCLES = OSC_STOP_US * CLK_MHZ;

	// Bus slave identity and command decoding; the address value is arbitrary.
	localparam logic [6:0] SLAVE_ADDR   = 7'h51;
	localparam logic [3:0] CMD_REG_ADDR = 4'hC;

	// Register offsets.
	localparam logic [3:0] OFF_SECONDS    = 4'h1;
	localparam logic [3:0] OFF_MINUTES    = 4'h2;
	localparam logic [3:0] OFF_DAY_WAVE   = 4'h4;
	localparam logic [3:0] OFF_CENT_MONTH = 4'h6;
	localparam logic [3:0] OFF_TRIM       = 4'h8;
	localparam logic [3:0] OFF_WATCHDOG   = 4'h9;
	localparam logic [3:0] OFF_ALM_MONTH  = 4'hA;
	localparam logic [3:0] OFF_FLAGS      = 4'hF;

	// Field positions.
	localparam int unsigned HALT_BIT     = 7;
	localparam int unsigned OSCFAIL_IRQ_EN_BIT = 7;
	localparam int unsigned RATE_LSB     = 4;
	localparam int unsigned CENT_LOW_BIT = 7;
	localparam int unsigned CENT_HI_BIT  = 6;
	localparam int unsigned TRIM_SIGN    = 5;
	localparam int unsigned ALARM_EN_BIT = 7;
	localparam int unsigned WAVE_EN_BIT  = 6;
	localparam int unsigned AF_BIT       = 6;
	localparam int unsigned OUT_BIT      = 3;
	localparam int unsigned OF_BIT       = 2;

	// Power-on values of the register file.
	localparam logic [7:0] RST_ZERO     = 8'h00;
	localparam logic [7:0] RST_DAY_WAVE = 8'h10;
	localparam logic [7:0] RST_FLAGS    = 8'h0C;

	// Oscillator cycles in a plain, a shortened and a lengthened second.
	localparam logic [15:0] SEC_NORMAL = 16'h8000;
	localparam logic [15:0] SEC_SHORT  = 16'h7F80;
	localparam logic [15:0] SEC_LONG   = 16'h8100;

endpackage

// >>> hdl/rtc_calibration_sqw_oscfail.sv
// Overview of operation
// - Trim adds or removes counts at divide-256 stage.
// - Trim magnitude is five low bits, 0..31.
// - Bit 5 sign: one slows, zero speeds.
// - 64-minute cycle; second -128 or +256 cycles.
// - Magnitude N trims first 2N minutes only.
// - Rate code selects wave; 0000 off, 1111 1Hz.
// - Wave enable gates wave onto shared pin.
// - Code 0110, enabled, running gives 512 Hz.
// - Trim never changes square wave frequency.
// - Century bits count binary; only 00 leaps.
// - Leap: divisible by 4, century rule applies.
// - Oscillator stop always sets the fail flag.
// - Halt bit stops oscillator, sets fail flag.
// - Fail flag and enable drive interrupt pin, wave off.
// - Fail flag sticky until written zero.
// - Power-on defaults for control bits.
// - Power-up wave selection is 32 kHz.
// - First byte after address is a command.
// - Alarm drives pin if enabled, wave off.
`timescale 1ns/1ps
`default_nettype none

module rtc_calibration_sqw_oscfail #(
	parameter int unsigned OSC_STOP_CYCLES = rtc_pkg::OSC_STOP_CYCLES
) (
	input  wire logic       i_clk,                 // System clock, 125 MHz.
	input  wire logic       i_resetn,              // Asynchronous reset, active low.
	input  wire logic       i_scl,                 // Serial bus clock level.
	input  wire logic       i_sda,                 // Serial bus data level.
	output var  logic       o_sda_o,               // Data drive value, always low.
	output var  logic       o_sda_oe,              // High while pulling data low.
	input  wire logic       i_osc_clk,             // Crystal oscillator level.
	output var  logic       o_osc_enable,          // Oscillator run enable.
	input  wire logic       i_alarm_flag,          // Alarm match flag.
	input  wire logic [7:0] i_year_bcd,            // Current year, BCD.
	input  wire logic       i_century_rollover,    // Year 99 to 00 pulse.
	output var  logic       o_alarm_irq_wave_pin_n, // Shared interrupt/wave pin.
	output var  logic       o_sec_tick,            // One-second pulse.
	output var  logic [1:0] o_century,             // Century count.
	output var  logic       o_leap_year            // Current year is leap.
);

	typedef enum logic [2:0] {
		BUS_IDLE  = 3'b000,
		BUS_ADDR  = 3'b001,
		BUS_ACK   = 3'b010,
		BUS_RX    = 3'b011,
		BUS_TX    = 3'b100,
		BUS_TXACK = 3'b101
	} bus_state_e;

	logic [7:0]  regs_r [16];
	logic [7:0]  reg_nxt [16];
	logic        scl_d_r, scl_q_r, sda_d_r, sda_q_r, osc_d_r, osc_q_r;
	logic        start_det, stop_det, scl_rise, scl_fall;
	bus_state_e  state_r;
	logic [2:0]  bit_cnt_r;
	logic [7:0]  shift_r, rd_data, wr_data_r;
	logic        byte_rdy_r, rd_mode_r, first_byte_r, cmd_valid_r, nack_r, wr_en_r;
	logic [3:0]  ptr_r, wr_addr_r;
	logic        halt, oscfail_irq_enable, of_flag, square_wave_enable, alarm_flag_enable;
	logic        out_lvl, trim_sign;
	logic [3:0]  wave_rate;
	logic [4:0]  trim_mag;
	logic        osc_tick, osc_stopped, of_set, wave_bit, trim_now;
	logic [19:0] idle_cnt_r;
	logic [14:0] presc_r;
	logic [15:0] sec_cnt_r, sec_len;
	logic [5:0]  sec_idx_r, min_idx_r;
	logic [1:0]  cent_nxt;

	// Control fields live in the register file.
	assign halt      = regs_r[rtc_pkg::OFF_SECONDS][rtc_pkg::HALT_BIT];
	assign oscfail_irq_enable = regs_r[rtc_pkg::OFF_MINUTES][rtc_pkg::OSCFAIL_IRQ_EN_BIT];
	assign wave_rate = regs_r[rtc_pkg::OFF_DAY_WAVE][rtc_pkg::RATE_LSB +: 4];
	assign trim_mag  = regs_r[rtc_pkg::OFF_TRIM][4:0];
	assign trim_sign = regs_r[rtc_pkg::OFF_TRIM][rtc_pkg::TRIM_SIGN];
	assign alarm_flag_enable  = regs_r[rtc_pkg::OFF_ALM_MONTH][rtc_pkg::ALARM_EN_BIT];
	assign square_wave_enable = regs_r[rtc_pkg::OFF_ALM_MONTH][rtc_pkg::WAVE_EN_BIT];
	assign of_flag   = regs_r[rtc_pkg::OFF_FLAGS][rtc_pkg::OF_BIT];
	assign out_lvl   = regs_r[rtc_pkg::OFF_FLAGS][rtc_pkg::OUT_BIT];

	// Bus pins are sampled once more to find edges; inputs are already synchronous.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			scl_d_r <= 1'b1;
			scl_q_r <= 1'b1;
			sda_d_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_d_r <= i_scl;
			scl_q_r <= scl_d_r;
			sda_d_r <= i_sda;
			sda_q_r <= sda_d_r;
		end
	end

	assign start_det = scl_d_r & scl_q_r & sda_q_r & ~sda_d_r;
	assign stop_det  = scl_d_r & scl_q_r & ~sda_q_r & sda_d_r;
	assign scl_rise  = scl_d_r & ~scl_q_r;
	assign scl_fall  = ~scl_d_r & scl_q_r;

	// The flags register shows the live alarm flag in its alarm position.
	always_comb begin
		rd_data = regs_r[ptr_r];
		if (ptr_r == rtc_pkg::OFF_FLAGS) begin
			rd_data[rtc_pkg::AF_BIT] = i_alarm_flag;
		end
	end

	// Serial slave: address, then a command byte, then data in or out.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r      <= BUS_IDLE;
			bit_cnt_r    <= 3'h0;
			shift_r      <= 8'h00;
			byte_rdy_r   <= 1'b0;
			rd_mode_r    <= 1'b0;
			first_byte_r <= 1'b0;
			cmd_valid_r  <= 1'b0;
			nack_r       <= 1'b0;
			ptr_r        <= 4'h0;
			o_sda_oe     <= 1'b0;
			wr_en_r      <= 1'b0;
			wr_addr_r    <= 4'h0;
			wr_data_r    <= 8'h00;
		end else begin
			wr_en_r <= 1'b0;
			if (start_det) begin
				state_r      <= BUS_ADDR;
				bit_cnt_r    <= 3'h0;
				byte_rdy_r   <= 1'b0;
				first_byte_r <= 1'b1;
				o_sda_oe     <= 1'b0;
			end else if (stop_det) begin
				state_r  <= BUS_IDLE;
				o_sda_oe <= 1'b0;
			end else begin
				unique case (state_r)
					BUS_IDLE: begin
						// Bytes without a preceding address are ignored.
						byte_rdy_r <= 1'b0;
					end
					BUS_ADDR, BUS_RX: begin
						if (scl_rise) begin
							shift_r    <= {shift_r[6:0], sda_d_r};
							bit_cnt_r  <= bit_cnt_r + 3'h1;
							byte_rdy_r <= (bit_cnt_r == 3'h7);
						end else if (scl_fall && byte_rdy_r) begin
							byte_rdy_r <= 1'b0;
							if (state_r == BUS_ADDR) begin
								if (shift_r[7:1] == rtc_pkg::SLAVE_ADDR) begin
									rd_mode_r <= shift_r[0];
									o_sda_oe  <= 1'b1;
									state_r   <= BUS_ACK;
								end else begin
									state_r <= BUS_IDLE;
								end
							end else if (first_byte_r) begin
								// The first byte is a command; it replaces the last one.
								first_byte_r <= 1'b0;
								cmd_valid_r  <= (shift_r[7:4] == rtc_pkg::CMD_REG_ADDR);
								if (shift_r[7:4] == rtc_pkg::CMD_REG_ADDR) begin
									ptr_r <= shift_r[3:0];
								end
								o_sda_oe <= 1'b1;
								state_r  <= BUS_ACK;
							end else begin
								if (cmd_valid_r) begin
									wr_en_r   <= 1'b1;
									wr_addr_r <= ptr_r;
									wr_data_r <= shift_r;
									ptr_r     <= ptr_r + 4'h1;
								end
								o_sda_oe <= 1'b1;
								state_r  <= BUS_ACK;
							end
						end
					end
					BUS_ACK: begin
						if (scl_fall) begin
							bit_cnt_r <= 3'h0;
							if (rd_mode_r) begin
								shift_r  <= rd_data;
								o_sda_oe <= ~rd_data[7];
								state_r  <= BUS_TX;
							end else begin
								o_sda_oe <= 1'b0;
								state_r  <= BUS_RX;
							end
						end
					end
					BUS_TX: begin
						if (scl_fall) begin
							bit_cnt_r <= bit_cnt_r + 3'h1;
							if (bit_cnt_r == 3'h7) begin
								o_sda_oe <= 1'b0;
								ptr_r    <= ptr_r + 4'h1;
								state_r  <= BUS_TXACK;
							end else begin
								o_sda_oe <= ~shift_r[6];
								shift_r  <= {shift_r[6:0], 1'b0};
							end
						end
					end
					BUS_TXACK: begin
						if (scl_rise) begin
							nack_r <= sda_d_r;
						end else if (scl_fall) begin
							bit_cnt_r <= 3'h0;
							if (nack_r) begin
								state_r <= BUS_IDLE;
							end else begin
								shift_r  <= rd_data;
								o_sda_oe <= ~rd_data[7];
								state_r  <= BUS_TX;
							end
						end
					end
					default: begin
						state_r <= BUS_IDLE;
					end
				endcase
			end
		end
	end

	assign o_sda_o = 1'b0;

	// Hardware updates merge with host writes; a fail event beats a clear.
	always_comb begin
		for (int k = 0; k < 16; k++) begin
			reg_nxt[k] = regs_r[k];
		end
		cent_nxt = {regs_r[rtc_pkg::OFF_CENT_MONTH][rtc_pkg::CENT_HI_BIT],
		            regs_r[rtc_pkg::OFF_CENT_MONTH][rtc_pkg::CENT_LOW_BIT]};
		if (wr_en_r) begin
			reg_nxt[wr_addr_r] = wr_data_r;
		end
		if (i_century_rollover) begin
			cent_nxt = cent_nxt + 2'h1;
			reg_nxt[rtc_pkg::OFF_CENT_MONTH][rtc_pkg::CENT_HI_BIT]  = cent_nxt[1];
			reg_nxt[rtc_pkg::OFF_CENT_MONTH][rtc_pkg::CENT_LOW_BIT] = cent_nxt[0];
		end
		if (of_set) begin
			reg_nxt[rtc_pkg::OFF_FLAGS][rtc_pkg::OF_BIT] = 1'b1;
		end
	end

	// One flop group per register entry, each with its power-on value.
	for (genvar g = 0; g < 16; g++) begin : g_regs
		localparam logic [7:0] RST_VAL =
			(g == int'(rtc_pkg::OFF_DAY_WAVE)) ? rtc_pkg::RST_DAY_WAVE :
			(g == int'(rtc_pkg::OFF_FLAGS))    ? rtc_pkg::RST_FLAGS : rtc_pkg::RST_ZERO;
		always_ff @(posedge i_clk or negedge i_resetn) begin
			if (!i_resetn) begin
				regs_r[g] <= RST_VAL;
			end else begin
				regs_r[g] <= reg_nxt[g];
			end
		end
	end

	// Crystal edges become ticks; a halted oscillator gives none.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			osc_d_r      <= 1'b0;
			osc_q_r      <= 1'b0;
			o_osc_enable <= 1'b1;
		end else begin
			osc_d_r      <= i_osc_clk;
			osc_q_r      <= osc_d_r;
			o_osc_enable <= ~halt;
		end
	end

	assign osc_tick = osc_d_r & ~osc_q_r & ~halt;

	// Loss of crystal edges for the whole window counts as a stop.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			idle_cnt_r <= 20'h0_0000;
		end else if (osc_d_r != osc_q_r) begin
			idle_cnt_r <= 20'h0_0000;
		end else if (!osc_stopped) begin
			idle_cnt_r <= idle_cnt_r + 20'h0_0001;
		end
	end

	assign osc_stopped = (idle_cnt_r >= 20'(OSC_STOP_CYCLES));
	assign of_set      = osc_stopped | halt;

	// Free-running prescaler feeds the wave taps, untouched by trim.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			presc_r <= 15'h0000;
		end else if (osc_tick) begin
			presc_r <= presc_r + 15'h0001;
		end
	end

	// Second length: trimmed at the divide-256 stage in early minutes only.
	assign trim_now = (sec_idx_r == 6'h00) && (min_idx_r < {trim_mag, 1'b0});
	always_comb begin
		sec_len = rtc_pkg::SEC_NORMAL;
		if (trim_now) begin
			sec_len = trim_sign ? rtc_pkg::SEC_LONG : rtc_pkg::SEC_SHORT;
		end
	end

	// Seconds counter; minute index wraps every 64 minutes by width.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sec_cnt_r  <= 16'h0000;
			sec_idx_r  <= 6'h00;
			min_idx_r  <= 6'h00;
			o_sec_tick <= 1'b0;
		end else begin
			o_sec_tick <= 1'b0;
			if (osc_tick) begin
				if (sec_cnt_r >= sec_len - 16'h0001) begin
					sec_cnt_r  <= 16'h0000;
					o_sec_tick <= 1'b1;
					if (sec_idx_r == 6'h3B) begin
						sec_idx_r <= 6'h00;
						min_idx_r <= min_idx_r + 6'h01;
					end else begin
						sec_idx_r <= sec_idx_r + 6'h01;
					end
				end else begin
					sec_cnt_r <= sec_cnt_r + 16'h0001;
				end
			end
		end
	end

	// Code 1 passes the crystal; code c taps prescaler bit c-1.
	always_comb begin
		wave_bit = 1'b1;
		if (wave_rate == 4'h1) begin
			wave_bit = osc_d_r;
		end else if (wave_rate != 4'h0) begin
			wave_bit = presc_r[wave_rate - 4'h1];
		end
	end

	// Shared pin priority: wave when enabled, else interrupts, else level.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_alarm_irq_wave_pin_n <= 1'b1;
		end else if (square_wave_enable) begin
			o_alarm_irq_wave_pin_n <= (wave_rate != 4'h0 && !halt) ? wave_bit : 1'b1;
		end else if ((oscfail_irq_enable && of_flag) || (alarm_flag_enable && i_alarm_flag)) begin
			o_alarm_irq_wave_pin_n <= 1'b0;
		end else begin
			o_alarm_irq_wave_pin_n <= out_lvl;
		end
	end

	// Leap year: BCD divisible by 4, and year 00 only in century 00.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_leap_year <= 1'b0;
			o_century   <= 2'h0;
		end else begin
			o_century   <= cent_nxt;
			o_leap_year <= (i_year_bcd[4] ? (i_year_bcd[3:0] == 4'h2 || i_year_bcd[3:0] == 4'h6)
			                             : (i_year_bcd[1:0] == 2'h0 && i_year_bcd[3:0] != 4'hC))
			               && (i_year_bcd != 8'h00 || cent_nxt == 2'h0);
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	// The enable pin is what actually stops the crystal, so watch it rather than the tick gate.
	property p_halt_stops_osc;
		halt |=> !o_osc_enable;
	endproperty
	a_halt_stops_osc: assert property (p_halt_stops_osc) else $error("oscillator left running");

	property p_halt_sets_of;
		halt |=> of_flag;
	endproperty
	a_halt_sets_of: assert property (p_halt_sets_of) else $error("halt left fail clear");

	property p_of_sticky;
		of_flag && !(wr_en_r && wr_addr_r == rtc_pkg::OFF_FLAGS) |=> of_flag;
	endproperty
	a_of_sticky: assert property (p_of_sticky) else $error("fail flag lost");

	property p_irq_on_fail;
		!square_wave_enable && oscfail_irq_enable && of_flag |=> !o_alarm_irq_wave_pin_n;
	endproperty
	a_irq_on_fail: assert property (p_irq_on_fail) else $error("pin not active");

	property p_pin_idle;
		!square_wave_enable && !(oscfail_irq_enable && of_flag)
			&& !(alarm_flag_enable && i_alarm_flag)
			|=> o_alarm_irq_wave_pin_n == $past(out_lvl);
	endproperty
	a_pin_idle: assert property (p_pin_idle) else $error("pin active without cause");

	property p_long_second;
		trim_sign && sec_idx_r == 6'h00 && min_idx_r == 6'h00 && trim_mag != 5'h00
			|-> sec_len == rtc_pkg::SEC_LONG;
	endproperty
	a_long_second: assert property (p_long_second) else $error("no lengthened second");

	property p_no_trim_late;
		{1'b0, min_idx_r} >= {1'b0, trim_mag, 1'b0} |-> sec_len == rtc_pkg::SEC_NORMAL;
	endproperty
	a_no_trim_late: assert property (p_no_trim_late) else $error("trim outside window");

	property p_presc_steady;
		osc_tick |=> presc_r == $past(presc_r) + 15'h0001;
	endproperty
	a_presc_steady: assert property (p_presc_steady) else $error("prescaler skipped");

	property p_century_count;
		i_century_rollover |=> o_century == $past(cent_nxt);
	endproperty
	a_century_count: assert property (p_century_count) else $error("century miscount");

	property p_write_needs_cmd;
		wr_en_r |-> $past(cmd_valid_r);
	endproperty
	a_write_needs_cmd: assert property (p_write_needs_cmd) else $error("write without command");

	c_of_set: cover property (halt ##1 of_flag);
	c_long_sec: cover property (o_sec_tick && trim_now && trim_sign);
	c_reg_write: cover property (wr_en_r);

endmodule // rtc_calibration_sqw_oscfail

`default_nettype wire

// >>> bench/rtc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host processor on the serial bus; clock is push-pull, data is open drain.
module rtc_host_model (
	input  wire logic i_clk,     // Bench clock.
	input  wire logic i_sda,     // Resolved data line.
	output var  logic o_scl,     // Serial clock.
	output var  logic o_sda_low  // High while pulling data low.
);
	int hp = 6;  // Clock high time in clocks, a third of a bit; the bench raises it to act as a slow host.

	// The bus idles released: clock driven high, data high through the pull-up.
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	// Data moves only while the clock is low, so no bit looks like a start or stop.
	task automatic bit_io(input logic b, output logic s);
		o_sda_low <= ~b;
		repeat (hp) @(posedge i_clk);
		o_scl <= 1'b1;
		repeat (hp) @(posedge i_clk);
		s = i_sda;
		o_scl <= 1'b0;
		repeat (hp) @(posedge i_clk);
	endtask

	// Start when up is low, stop when up is high; data moves while the clock is high.
	task automatic frame_mark(input logic up);
		o_sda_low <= up;
		repeat (hp) @(posedge i_clk);
		o_scl <= 1'b1;
		repeat (hp) @(posedge i_clk);
		o_sda_low <= ~up;
		repeat (hp) @(posedge i_clk);
		if (!up) begin
			o_scl <= 1'b0;
			repeat (hp) @(posedge i_clk);
		end
	endtask

	// Eight bits most significant first, then the device's acknowledge.
	task automatic byte_out(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(v[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask

	// Single byte read, closed by a not-acknowledge.
	task automatic byte_in(output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			v[i] = s;
		end
		bit_io(1'b1, s);
	endtask

	// Address, command with register index, optional data byte.
	task automatic write_frame(input logic [6:0] a, input logic [3:0] idx,
		input logic [7:0] v, input logic with_data, output logic ack);
		logic k1;
		logic k2;
		logic k3;
		frame_mark(1'b0);
		byte_out({a, 1'b0}, k1);
		byte_out({rtc_pkg::CMD_REG_ADDR, idx}, k2);
		k3 = 1'b1;
		if (with_data) byte_out(v, k3);
		frame_mark(1'b1);
		ack = k1 & k2 & k3;
	endtask

	// The pointer is set by a command-only write, then read in a new transfer.
	task automatic read_reg(input logic [3:0] idx, output logic [7:0] v);
		logic k;
		write_frame(rtc_pkg::SLAVE_ADDR, idx, 8'h00, 1'b0, k);
		frame_mark(1'b0);
		byte_out({rtc_pkg::SLAVE_ADDR, 1'b1}, k);
		byte_in(v);
		frame_mark(1'b1);
	endtask
endmodule // rtc_host_model

`default_nettype wire

// >>> bench/rtc_calibration_sqw_oscfail_test.sv
`timescale 1ns/1ps
`default_nettype none

module rtc_calibration_sqw_oscfail_test;
	logic            clk = 1'b0;
	logic            resetn = 1'b0;
	logic            osc_clk = 1'b0;
	logic            osc_ph = 1'b0;
	logic            osc_run = 1'b1;
	int              osc_rises = 0;
	logic            alarm = 1'b0;
	logic [7:0]      year = 8'h00;
	logic            roll = 1'b0;
	wire logic       scl, sda_low, sda, sda_o, sda_oe, osc_en, pin, leap, sec_tick;
	wire logic [1:0] century;
	int              n_mismatch = 0;
	int              samples_checked = 0;
	int              sec_ticks = 0;
	int              cnt;
	logic [7:0]      d;
	logic            ack;
	logic [3:0]      didx [5] = '{4'h4, 4'hA, 4'hF, 4'h1, 4'h2};
	logic [7:0]      dval [5] = '{8'h10, 8'h00, 8'h0C, 8'h00, 8'h00};
	logic [7:0]      ytab [5] = '{8'h04, 8'h01, 8'h96, 8'h10, 8'h00};
	logic            ltab [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

	// Pull-up on data: low when either party pulls it.
	assign sda = ~(sda_low | (sda_oe & ~sda_o));

	always #4 clk = ~clk;

	// The whole run, at most 100000 clocks, is shorter than one second of at least 130560 clocks, so any tick means a broken divider.
	always @(posedge clk) begin
		if (sec_tick === 1'b1) sec_ticks <= sec_ticks + 1;
	end

	// Crystal scaled to four clocks a period so that wave periods stay short.
	always @(posedge clk) begin
		if (osc_run && osc_en) begin
			osc_ph <= ~osc_ph;
			if (osc_ph) begin
				osc_clk <= ~osc_clk;
				if (!osc_clk) osc_rises <= osc_rises + 1;
			end
		end
	end

	rtc_calibration_sqw_oscfail #(.OSC_STOP_CYCLES(64)) dut (
		.i_clk(clk), .i_resetn(resetn), .i_scl(scl), .i_sda(sda),
		.o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_osc_clk(osc_clk), .o_osc_enable(osc_en),
		.i_alarm_flag(alarm), .i_year_bcd(year), .i_century_rollover(roll),
		.o_alarm_irq_wave_pin_n(pin), .o_sec_tick(sec_tick), .o_century(century), .o_leap_year(leap)
	);

	rtc_host_model host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

	task automatic stop_test();
		if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			n_mismatch++;
		end
	endtask

	task automatic wreg(input logic [3:0] idx, input logic [7:0] v);
		host.write_frame(rtc_pkg::SLAVE_ADDR, idx, v, 1'b1, ack);
		check("write_ack", 16'h0001, ack);
	endtask

	task automatic rchk(input logic [3:0] idx, input logic [7:0] v, input string what);
		host.read_reg(idx, d);
		check(what, v, d);
	endtask

	// Counts the cycles the pin spends at the wanted level; any glitch shows.
	task automatic pin_hold(input logic v, input int n);
		int hits;
		hits = 0;
		repeat (n) begin
			@(negedge clk);
			if (pin === v) hits++;
		end
		check("pin_cycles", n, hits);
	endtask

	task automatic wait_rise();
		logic p;
		int i;
		p = pin;
		for (i = 0; i < 5000; i++) begin
			@(negedge clk);
			if (p === 1'b0 && pin === 1'b1) break;
			p = pin;
		end
		if (i == 5000) begin
			n_mismatch++;
			stop_test();
		end
	endtask

	// Crystal periods per wave period; the first interval after a change is dropped.
	task automatic period(output int c);
		int r0;
		wait_rise();
		wait_rise();
		r0 = osc_rises;
		wait_rise();
		c = osc_rises - r0;
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end

	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		check("osc_enable", 16'h0001, osc_en);
		check("pin", 16'h0001, pin);
		for (int k = 0; k < 5; k++) rchk(didx[k], dval[k], "reset_reg");
		host.hp = 20;
		host.write_frame(rtc_pkg::SLAVE_ADDR ^ 7'h01, rtc_pkg::OFF_TRIM, 8'h15, 1'b1, ack);
		check("foreign_ack", 16'h0000, ack);
		rchk(rtc_pkg::OFF_TRIM, 8'h00, "trim");
		wreg(rtc_pkg::OFF_TRIM, 8'h3F);
		rchk(rtc_pkg::OFF_TRIM, 8'h3F, "trim");
		host.hp = 6;
		wreg(rtc_pkg::OFF_ALM_MONTH, 8'h40);
		period(cnt);
		check("period", 16'h0001, cnt[15:0]);
		for (int c = 2; c < 10; c++) begin
			wreg(rtc_pkg::OFF_DAY_WAVE, {c[3:0], 4'h0});
			period(cnt);
			check("period", 16'h0001 << c, cnt[15:0]);
		end
		wreg(rtc_pkg::OFF_DAY_WAVE, 8'h60);
		wreg(rtc_pkg::OFF_TRIM, 8'h1F);
		period(cnt);
		check("period", 16'h0040, cnt[15:0]);
		wreg(rtc_pkg::OFF_DAY_WAVE, 8'h00);
		pin_hold(1'b1, 300);
		wreg(rtc_pkg::OFF_ALM_MONTH, 8'h00);
		pin_hold(1'b1, 100);
		// Fail flag is still set from power-on; enabling its interrupt pulls the pin.
		wreg(rtc_pkg::OFF_MINUTES, 8'h80);
		pin_hold(1'b0, 20);
		rchk(rtc_pkg::OFF_FLAGS, 8'h0C, "flags");
		pin_hold(1'b0, 20);
		wreg(rtc_pkg::OFF_FLAGS, 8'h08);
		pin_hold(1'b1, 20);
		rchk(rtc_pkg::OFF_FLAGS, 8'h08, "flags");
		wreg(rtc_pkg::OFF_SECONDS, 8'h80);
		check("osc_enable", 16'h0000, osc_en);
		pin_hold(1'b0, 20);
		wreg(rtc_pkg::OFF_SECONDS, 8'h00);
		check("osc_enable", 16'h0001, osc_en);
		rchk(rtc_pkg::OFF_FLAGS, 8'h0C, "flags");
		wreg(rtc_pkg::OFF_FLAGS, 8'h08);
		// The crystal dies on its own; the loss window is 64 clocks here.
		osc_run <= 1'b0;
		repeat (200) @(posedge clk);
		pin_hold(1'b0, 20);
		rchk(rtc_pkg::OFF_FLAGS, 8'h0C, "flags");
		osc_run <= 1'b1;
		wreg(rtc_pkg::OFF_MINUTES, 8'h00);
		pin_hold(1'b1, 20);
		alarm <= 1'b1;
		pin_hold(1'b1, 20);
		wreg(rtc_pkg::OFF_ALM_MONTH, 8'h80);
		pin_hold(1'b0, 20);
		wreg(rtc_pkg::OFF_ALM_MONTH, 8'hC0);
		pin_hold(1'b1, 20);
		alarm <= 1'b0;
		wreg(rtc_pkg::OFF_ALM_MONTH, 8'h00);
		for (int k = 0; k < 5; k++) begin
			year <= ytab[k];
			repeat (3) @(posedge clk);
			check("leap", ltab[k], leap);
		end
		// Four rollovers walk the century count round to 00 again.
		for (int k = 1; k < 5; k++) begin
			roll <= 1'b1;
			@(posedge clk);
			roll <= 1'b0;
			repeat (3) @(posedge clk);
			check("century", k[1:0], century);
			check("leap", (k % 4) == 0, leap);
			if (k == 1) rchk(rtc_pkg::OFF_CENT_MONTH, 8'h80, "century_reg");
		end
		check("sec_tick", 16'h0000, sec_ticks[15:0]);
		stop_test();
	end
endmodule // rtc_calibration_sqw_oscfail_test

`default_nettype wire
